// ===== rtl/dgc_pkg.sv
// Register map, field positions and reset values of the config bank
package dgc_pkg;
  // Register addresses on the register access port
  localparam logic [7:0] DGC_DEV_CFG_ADDR = 8'h4C;
  localparam logic [7:0] DGC_PIN_CFG_ADDR = 8'h4D;
  // Reset values
  localparam logic [15:0] DGC_DEV_CFG_RST = 16'h0000;
  localparam logic [15:0] DGC_PIN_CFG_RST = 16'h0000;
  // writable bits; reserved bits read zero, except device config bit 13, which is writable
  localparam logic [15:0] DGC_DEV_CFG_WMASK = 16'h7B00;
  localparam logic [15:0] DGC_PIN_CFG_WMASK = 16'h7FFD;
  // Device config field positions
  localparam int DGC_READY_SEL_POS = 14;
  localparam int DGC_RSVD_WR_POS = 13;
  localparam int DGC_CLK_SRC_POS = 12;
  localparam int DGC_WORD_LEN_POS = 11;
  localparam int DGC_MODE_LSB = 8;
  localparam int DGC_MODE_MSB = 9;
  // Pin config field positions
  localparam int DGC_FMT_LSB = 10;
  localparam int DGC_FMT_MSB = 14;
  localparam int DGC_DIR_LSB = 5;
  localparam int DGC_DIR_MSB = 9;
  localparam int DGC_SRC_HI_LSB = 2;
  localparam int DGC_SRC_HI_MSB = 4;
  localparam int DGC_SRC0_POS = 0;
  // Pin and converter counts, word widths
  localparam int DGC_PIN_N = 5;
  localparam int DGC_CONV_N = 4;
  localparam int DGC_WORD_W = 24;
  localparam int DGC_WIDE_W = 32;
  // Operating mode codes
  localparam logic [1:0] DGC_MODE_ACTIVE = 2'h0;
  localparam logic [1:0] DGC_MODE_STANDBY = 2'h1;
  // Output reset levels
  localparam logic DGC_READY_N_RST = 1'h1;
endpackage : dgc_pkg

// ===== rtl/dgc_sel_reg.sv
// Registered per-bit two-way selector
`timescale 1ns/1ps
module dgc_sel_reg #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Select and the two sources
  input wire logic [W-1:0] sel_in,
  input wire logic [W-1:0] a_in,
  input wire logic [W-1:0] b_in,
  // Registered result
  output logic [W-1:0] q_out
);
  logic [W-1:0] next_q;

  // Bit set in select takes source b
  always_comb begin
    next_q = (sel_in & b_in) | (~sel_in & a_in);
  end

  // Result register
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_out <= RST;
    end else begin
      q_out <= next_q;
    end
  end
endmodule : dgc_sel_reg

// ===== rtl/dgc_cfg_regs.sv
// Device and pin configuration register bank with its selection logic
// Operation
// - Ready select 0 routes first converter pair ready, 1 the second pair.
// - Clock source select 0 picks internal oscillator, 1 external clock.
// - Word length select 0 gives 24-bit words, 1 gives 32-bit words.
// - In 32-bit mode words are padded with zeros at the low end.
// - Mode code 00 selects active, 01 selects standby.
// - Standby holds every converter disabled.
// - Mode codes 10 and 11 both select power-down, identically.
// - Pin config register sits at 4Dh and resets to 0000h.
// - Pin config bits 14..10 are formats, bits 9..8 directions of pins 4,3.
// - Low byte: directions 2..0, sources 4..2, reserved zero, pin 0 source.
// - Format 0 gives static levels, 1 gives PWM decode and drive.
// - Device config register sits at 4Ch and resets to 0000h.
`timescale 1ns/1ps
module dgc_cfg_regs
  import dgc_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Register access port from the serial frame decoder
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  // Converter ready indications, active low
  input wire logic pair_a_ready_n_in,
  input wire logic pair_b_ready_n_in,
  output logic conversion_ready_n_out,
  // Clock, word length and mode selections
  output logic clock_source_sel_out,
  output logic word_length_32_out,
  output logic [1:0] operating_mode_sel_out,
  output logic standby_out,
  output logic power_down_out,
  // Converter enables: current a, current b, voltage a, voltage b
  input wire logic [DGC_CONV_N-1:0] conv_enable_req_in,
  output logic [DGC_CONV_N-1:0] conv_enable_out,
  // Data words towards the serial frame
  input wire logic word_valid_in,
  input wire logic [DGC_WORD_W-1:0] word_in,
  output logic word_valid_out,
  output logic [DGC_WIDE_W-1:0] word_out,
  // Pin levels, static and PWM paths
  input wire logic [DGC_PIN_N-1:0] pin_static_in,
  input wire logic [DGC_PIN_N-1:0] pin_pwm_in,
  output logic [DGC_PIN_N-1:0] pin_level_out,
  input wire logic [DGC_PIN_N-1:0] drive_static_in,
  input wire logic [DGC_PIN_N-1:0] drive_pwm_in,
  output logic [DGC_PIN_N-1:0] pin_drive_out,
  // Pin configuration fields
  output logic [DGC_PIN_N-1:0] pin_format_out,
  output logic [DGC_PIN_N-1:0] pin_direction_out,
  output logic [DGC_PIN_N-1:0] pin_source_out
);
  logic [15:0] device_config;
  logic [15:0] pin_function_config;
  logic [15:0] next_device_config;
  logic [15:0] next_pin_function_config;
  logic [15:0] next_rdata;
  logic next_rdata_valid;
  logic [1:0] next_mode;
  logic next_standby;
  logic next_power_down;
  logic [DGC_CONV_N-1:0] next_conv_enable;
  logic next_word_valid;
  logic [DGC_WIDE_W-1:0] next_word;
  logic [DGC_PIN_N-1:0] fmt;
  logic [DGC_PIN_N-1:0] next_direction;
  logic [DGC_PIN_N-1:0] next_source;
  logic dev_hit;
  logic pin_hit;

  assign dev_hit = reg_addr_in == DGC_DEV_CFG_ADDR;
  assign pin_hit = reg_addr_in == DGC_PIN_CFG_ADDR;
  assign fmt = pin_function_config[DGC_FMT_MSB:DGC_FMT_LSB];

  // Register writes, reserved read-only bits masked off
  always_comb begin
    next_device_config = device_config;
    next_pin_function_config = pin_function_config;
    if (reg_wr_in && dev_hit) begin
      next_device_config = reg_wdata_in & DGC_DEV_CFG_WMASK;
    end
    if (reg_wr_in && pin_hit) begin
      next_pin_function_config = reg_wdata_in & DGC_PIN_CFG_WMASK;
    end
  end

  // Register read-back; unmapped addresses read zero
  always_comb begin
    next_rdata = 16'h0000;
    next_rdata_valid = reg_rd_in;
    if (reg_rd_in && dev_hit) begin
      next_rdata = device_config;
    end else if (reg_rd_in && pin_hit) begin
      next_rdata = pin_function_config;
    end
  end

  // Configuration and read-back registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      device_config <= DGC_DEV_CFG_RST;
      pin_function_config <= DGC_PIN_CFG_RST;
      reg_rdata_out <= 16'h0000;
      reg_rdata_valid_out <= 1'h0;
    end else begin
      device_config <= next_device_config;
      pin_function_config <= next_pin_function_config;
      reg_rdata_out <= next_rdata;
      reg_rdata_valid_out <= next_rdata_valid;
    end
  end

  // clock source select straight from its bit
  assign clock_source_sel_out = device_config[DGC_CLK_SRC_POS];
  // word length select straight from its bit
  assign word_length_32_out = device_config[DGC_WORD_LEN_POS];

  // Mode decode and converter gating
  always_comb begin
    next_mode = device_config[DGC_MODE_MSB:DGC_MODE_LSB];
    next_standby = next_mode == DGC_MODE_STANDBY;
    next_power_down = next_mode[1];
    // converters run only in active mode
    if (next_mode == DGC_MODE_ACTIVE) begin
      next_conv_enable = conv_enable_req_in;
    end else begin
      next_conv_enable = '0;
    end
  end

  // Mode output registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      operating_mode_sel_out <= DGC_MODE_ACTIVE;
      standby_out <= 1'h0;
      power_down_out <= 1'h0;
      conv_enable_out <= '0;
    end else begin
      operating_mode_sel_out <= next_mode;
      standby_out <= next_standby;
      power_down_out <= next_power_down;
      conv_enable_out <= next_conv_enable;
    end
  end

  // Word widening for the serial frame
  always_comb begin
    next_word_valid = word_valid_in;
    // zero padding at the low end for 32-bit words, at the high end for 24-bit words
    if (device_config[DGC_WORD_LEN_POS]) begin
      next_word = {word_in, 8'h00};
    end else begin
      next_word = {8'h00, word_in};
    end
  end

  // Word output registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_valid_out <= 1'h0;
      word_out <= '0;
    end else begin
      word_valid_out <= next_word_valid;
      word_out <= next_word;
    end
  end

  dgc_sel_reg #(
    .W(1),
    .RST(DGC_READY_N_RST)
  ) u_ready_sel (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .sel_in(device_config[DGC_READY_SEL_POS]),
    .a_in(pair_a_ready_n_in),
    .b_in(pair_b_ready_n_in),
    .q_out(conversion_ready_n_out)
  );

  // input level path per pin format
  dgc_sel_reg #(
    .W(DGC_PIN_N),
    .RST('0)
  ) u_level_sel (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .sel_in(fmt),
    .a_in(pin_static_in),
    .b_in(pin_pwm_in),
    .q_out(pin_level_out)
  );

  // output drive path per pin format
  dgc_sel_reg #(
    .W(DGC_PIN_N),
    .RST('0)
  ) u_drive_sel (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .sel_in(fmt),
    .a_in(drive_static_in),
    .b_in(drive_pwm_in),
    .q_out(pin_drive_out)
  );

  // Pin field unpacking; pin 1 has no source bit
  always_comb begin
    // directions of pins 4 down to 0
    next_direction = pin_function_config[DGC_DIR_MSB:DGC_DIR_LSB];
    // sources of pins 4..2 and 0
    next_source = {pin_function_config[DGC_SRC_HI_MSB:DGC_SRC_HI_LSB],
      1'h0, pin_function_config[DGC_SRC0_POS]};
  end

  // Pin field output registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_format_out <= '0;
      pin_direction_out <= '0;
      pin_source_out <= '0;
    end else begin
      pin_format_out <= fmt;
      pin_direction_out <= next_direction;
      pin_source_out <= next_source;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  ready_route_a: assert property (
    $past(rst_b_in) |-> conversion_ready_n_out ==
      ($past(device_config[DGC_READY_SEL_POS])
      ? $past(pair_b_ready_n_in) : $past(pair_a_ready_n_in)))
    else $error("ready pin not from selected pair");

  clk_source_a: assert property (
    reg_wr_in && dev_hit |=> clock_source_sel_out == $past(reg_wdata_in[12]))
    else $error("clock source select not updated");

  word_length_a: assert property (
    reg_wr_in && dev_hit |=> word_length_32_out == $past(reg_wdata_in[11]))
    else $error("word length select not updated");

  // wide words carry the sample high
  word_pad_a: assert property (
    word_valid_in && device_config[DGC_WORD_LEN_POS]
      |=> word_valid_out && word_out == {$past(word_in), 8'h00})
    else $error("wide word not zero padded");

  mode_active_a: assert property (
    device_config[9:8] == 2'h0 |=> !standby_out && !power_down_out
      && conv_enable_out == $past(conv_enable_req_in))
    else $error("active mode decode wrong");

  standby_off_a: assert property (
    device_config[9:8] == 2'h1 |=> standby_out && conv_enable_out == '0)
    else $error("converter enabled in standby");

  power_down_a: assert property (
    device_config[9] |=> power_down_out && !standby_out
      && conv_enable_out == '0)
    else $error("power-down decode wrong");

  pin_read_a: assert property (
    reg_rd_in && pin_hit |=> reg_rdata_valid_out
      && reg_rdata_out == $past(pin_function_config))
    else $error("pin config read-back wrong");

  dev_write_a: assert property (
    reg_wr_in && dev_hit ##1 reg_rd_in && dev_hit |=>
      reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h7B00))
    else $error("device config write not kept");

  rsvd_zero_a: assert property (
    pin_function_config[15] == 1'h0 && pin_function_config[1] == 1'h0
      && device_config[15] == 1'h0 && device_config[10] == 1'h0
      && device_config[7:0] == 8'h00)
    else $error("reserved bit set");

  // format picks the PWM drive path
  fmt_drive_a: assert property (
    $past(rst_b_in) |-> pin_drive_out == (($past(fmt) & $past(drive_pwm_in))
      | (~$past(fmt) & $past(drive_static_in))))
    else $error("pin drive path not per format");

  // format field lands on format outputs
  pin_fields_a: assert property (
    reg_wr_in && pin_hit |=> ##1 pin_format_out == $past(reg_wdata_in[14:10], 2)
      && pin_direction_out == $past(reg_wdata_in[9:5], 2))
    else $error("pin format or direction field wrong");

  // source bits with pin 1 always zero
  pin_source_a: assert property (
    pin_source_out[1] == 1'h0 && pin_source_out[0] ==
      $past(pin_function_config[0]))
    else $error("pin source field wrong");
endmodule : dgc_cfg_regs

// ===== tb/dgc_host_model.sv
// Host controller model driving the register access port
`timescale 1ns/1ps
module dgc_host_model
  import dgc_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // Register access port
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_addr_out,
  output logic [15:0] reg_wdata_out,
  input wire logic [15:0] reg_rdata_in,
  input wire logic reg_rdata_valid_in
);
  logic [15:0] last_cfg;

  // Idle port after time zero
  initial begin
    reg_wr_out = 1'h0;
    reg_rd_out = 1'h0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 16'h0000;
    last_cfg = 16'h0000;
  end

  // One write strobe, released lines show the inverse
  task automatic drive(input logic [7:0] addr, input logic [15:0] data);
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'h1;
    reg_addr_out = addr;
    reg_wdata_out = data;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'h0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
  endtask : drive

  // Write keeping the host-side duties
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = data;
    if (addr == DGC_DEV_CFG_ADDR) begin
      d[13] = 1'h0;
      if (d[12] != last_cfg[12] && last_cfg[9:8] == DGC_MODE_ACTIVE) begin
        drive(addr, {last_cfg[15:10], DGC_MODE_STANDBY, last_cfg[7:0]});
      end
      // single clock keeps running through switch
      last_cfg = d;
    end
    drive(addr, d);
  endtask : write_reg

  // Write, then read back in the very next cycle
  task automatic write_read(input logic [7:0] addr, input logic [15:0] data,
                            output logic [15:0] rdata);
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'h1;
    reg_addr_out = addr;
    reg_wdata_out = data;
    @(posedge mclk_in);
    #1;
    reg_wr_out = 1'h0;
    reg_rd_out = 1'h1;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'h0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
    rdata = reg_rdata_in;
    if (addr == DGC_DEV_CFG_ADDR) begin
      last_cfg = data;
    end
  endtask : write_read

  // One read strobe, answer taken in the following cycle
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data,
                          output logic valid);
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'h1;
    reg_addr_out = addr;
    @(posedge mclk_in);
    #1;
    reg_rd_out = 1'h0;
    reg_addr_out = ~addr;
    data = reg_rdata_in;
    valid = reg_rdata_valid_in;
  endtask : read_reg
endmodule : dgc_host_model

// ===== tb/test_device_and_gpio_config_regs.sv
// Self-checking bench for the config register bank
`timescale 1ns/1ps
module test_device_and_gpio_config_regs;
  import dgc_pkg::*;
  logic mclk_in, rst_b_in, wr, rd, rdv, wv_in, wv_out, pa_n, pb_n;
  logic rdy_n, clk_sel, w32, sb, pd, v;
  logic [1:0] mode;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rv;
  logic [3:0] req, en;
  logic [23:0] w_in;
  logic [31:0] w_out;
  logic [4:0] ps, pp, lvl, ds, dp, drv, fmt, dir, src;
  int err_count, num_checks;

  dgc_host_model host (.mclk_in(mclk_in), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .reg_rdata_valid_in(rdv));

  dgc_cfg_regs DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rdata_valid_out(rdv),
    .pair_a_ready_n_in(pa_n), .pair_b_ready_n_in(pb_n),
    .conversion_ready_n_out(rdy_n), .clock_source_sel_out(clk_sel),
    .word_length_32_out(w32), .operating_mode_sel_out(mode),
    .standby_out(sb), .power_down_out(pd), .conv_enable_req_in(req),
    .conv_enable_out(en), .word_valid_in(wv_in), .word_in(w_in),
    .word_valid_out(wv_out), .word_out(w_out), .pin_static_in(ps),
    .pin_pwm_in(pp), .pin_level_out(lvl), .drive_static_in(ds),
    .drive_pwm_in(dp), .pin_drive_out(drv), .pin_format_out(fmt),
    .pin_direction_out(dir), .pin_source_out(src));

  // Clock generation
  initial begin
    mclk_in = 1'h0;
    forever #2 mclk_in = ~mclk_in;
  end

  // Counts and verdict
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Compare one value
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  // Read and compare data and valid pulse
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    host.read_reg(a, rv, v);
    check(v, 1'h1);
    check(rv, exp);
  endtask : rd_chk

  // Let registered selections settle
  task automatic settle;
    repeat (3) @(posedge mclk_in);
    #1;
  endtask : settle

  // Reset values and unmapped read
  task automatic test_reset;
    rd_chk(DGC_DEV_CFG_ADDR, 16'h0000);
    rd_chk(DGC_PIN_CFG_ADDR, 16'h0000);
    rd_chk(8'h4E, 16'h0000);
    check(clk_sel, 1'h0);
  endtask : test_reset

  // Device config fields and their effects
  task automatic test_dev;
    host.write_reg(DGC_DEV_CFG_ADDR, 16'h0100);
    settle;
    check(sb, 1'h1);
    check(en, 4'h0);
    host.write_reg(DGC_DEV_CFG_ADDR, 16'h5900);
    settle;
    check(clk_sel, 1'h1);
    check(w32, 1'h1);
    check(rdy_n, 1'h1);
    check(w_out, 32'hABCDEF00);
    check(wv_out, 1'h1);
    host.write_reg(DGC_DEV_CFG_ADDR, 16'hFFFF);
    settle;
    rd_chk(DGC_DEV_CFG_ADDR, 16'h5B00);
    check({pd, sb, en}, 6'h20);
    host.write_reg(DGC_DEV_CFG_ADDR, 16'h5A00);
    settle;
    check({pd, mode}, 3'h6);
    host.write_reg(8'h4E, 16'hFFFF);
    rd_chk(DGC_DEV_CFG_ADDR, 16'h5A00);
    host.write_read(DGC_DEV_CFG_ADDR, 16'h5900, rv);
    check(rv, 16'h5900);
    host.write_reg(DGC_DEV_CFG_ADDR, 16'h0000);
    settle;
    check(en, 4'hF);
    check(rdy_n, 1'h0);
    check(clk_sel, 1'h0);
    check(w_out, 32'h00ABCDEF);
    check({pd, sb}, 2'h0);
  endtask : test_dev

  // Pin config fields and level selection
  task automatic test_pin;
    host.write_reg(DGC_PIN_CFG_ADDR, 16'hFFFF);
    settle;
    rd_chk(DGC_PIN_CFG_ADDR, 16'h7FFD);
    check({fmt, dir, src}, 15'h7FFD);
    check({lvl, drv}, 10'h0D3);
    host.write_reg(DGC_PIN_CFG_ADDR, 16'h5555);
    settle;
    rd_chk(DGC_PIN_CFG_ADDR, 16'h5555);
    check({fmt, dir, src}, 15'h5555);
    check({lvl, drv}, 10'h199);
    host.write_reg(DGC_PIN_CFG_ADDR, 16'h0000);
    settle;
    check({lvl, drv}, 10'h32C);
  endtask : test_pin

  // Hang guard
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end

  // Main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    rst_b_in = 1'h0;
    pa_n = 1'h0;
    pb_n = 1'h1;
    req = 4'hF;
    wv_in = 1'h1;
    w_in = 24'hABCDEF;
    ps = 5'h19;
    pp = 5'h06;
    ds = 5'h0C;
    dp = 5'h13;
    repeat (8) @(posedge mclk_in);
    #1;
    check(rdy_n, DGC_READY_N_RST);
    rst_b_in = 1'h1;
    test_reset;
    test_dev;
    test_pin;
    print_verdict;
  end
endmodule : test_device_and_gpio_config_regs
